// ---- src/pec_consts.svh ----
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH
`define PEC_FN_COUNT_RESET   7'h1C
`define PEC_FN_COUNT_TRIGGER 7'h1F
`define PEC_OUT_SET_REACHED  6'h12
`define PEC_OUT_DESIG_REACHED 6'h13
`define PEC_TYPE_PULSE       4'h0
`define PEC_TYPE_DIGITAL     4'h1
`define PEC_TYPE_SPEED       4'h2
`define PEC_TYPE_ONES_LSB    0
`define PEC_TYPE_TENS_LSB    4
`define PEC_COUNT_RESET_VAL  16'h0000
`endif

// ---- src/pec_pkg.sv ----
package pec_pkg;
  typedef logic [15:0] pec_count_t;
  typedef enum logic [2:0] {
    PEC_IN_PULSE   = 3'b001,
    PEC_IN_DIGITAL = 3'b010,
    PEC_IN_SPEED   = 3'b100
  } pec_in_type_t;
endpackage

// ---- src/pec_counter.sv ----
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_counter #(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // terminal pins
  input  wire logic       fast_input_a,
  input  wire logic       fast_input_b,
  // configuration
  input  wire logic [7:0] hs_input_type_select,
  input  wire logic [6:0] hs_input_one_function,
  input  wire logic [6:0] hs_input_two_function,
  input  wire logic [15:0] set_count_value,
  input  wire logic [15:0] designated_count_value,
  input  wire logic [5:0] digital_output_a_function,
  input  wire logic [5:0] fast_output_a_function,
  input  wire logic [5:0] relay_output_a_function,
  input  wire logic [5:0] relay_output_b_function,
  // status
  output logic [15:0]     accumulated_count,
  output logic [1:0]      input_a_type,
  output logic [1:0]      input_b_type,
  output logic            set_reached,
  output logic            designated_reached,
  // outputs
  output logic            digital_output_a,
  output logic            fast_output_a,
  output logic            relay_output_a,
  output logic            relay_output_b
);
  if (COUNT_W != 16) begin : g_chk
    $error("pec_counter: COUNT_W must be 16");
  end

  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] prev;
  logic [1:0] level;
  logic [1:0] rise;
  logic [6:0] fn [2];
  logic [3:0] tdig [2];
  logic [1:0] trig;
  logic [1:0] clr;
  pec_pkg::pec_count_t desig_eff;
  logic       any_trig;
  logic       any_clr;
  logic       hit_set;
  logic       hit_desig;
  pec_pkg::pec_count_t next_count;
  logic [3:0] ofn_sel_set;
  logic [3:0] ofn_sel_des;
  logic [5:0] ofn [4];
  logic [3:0] next_out;

  // two-stage synchronisers, first stage read only by the second
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      prev   <= 2'h0;
    end else begin
      sync_a <= {sync_a[0], fast_input_a};
      sync_b <= {sync_b[0], fast_input_b};
      prev   <= level;
    end
  end

  assign level = {sync_b[1], sync_a[1]};
  assign rise  = level & ~prev;
  assign fn[0] = hs_input_one_function;
  assign fn[1] = hs_input_two_function;
  assign tdig[0] = hs_input_type_select[`PEC_TYPE_ONES_LSB +: 4];
  assign tdig[1] = hs_input_type_select[`PEC_TYPE_TENS_LSB +: 4];

  // a terminal in pulse or speed mode does not serve as a discrete function input
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_term
    logic is_dig;
    assign is_dig   = (tdig[gi] == `PEC_TYPE_DIGITAL);
    assign trig[gi] = is_dig && (fn[gi] == `PEC_FN_COUNT_TRIGGER) && rise[gi];
    assign clr[gi]  = is_dig && (fn[gi] == `PEC_FN_COUNT_RESET) && level[gi];
  end

  assign input_a_type = tdig[0][1:0];
  assign input_b_type = tdig[1][1:0];

  // designated never exceeds set; clamp rather than trust the configuration
  assign desig_eff = (designated_count_value > set_count_value) ?
                     set_count_value : designated_count_value;
  assign any_trig  = |trig;
  assign any_clr   = |clr;
  assign hit_set   = (accumulated_count == set_count_value);
  assign hit_desig = (accumulated_count == desig_eff);

  // reaching set shows for one count period before restart, so outputs can see equality
  always_comb begin
    next_count = accumulated_count;
    if (any_clr) begin
      next_count = `PEC_COUNT_RESET_VAL;
    end else if (any_trig) begin
      if (hit_set) begin
        next_count = `PEC_COUNT_RESET_VAL;
      end else begin
        next_count = 16'(accumulated_count + 16'h0001);
      end
    end
  end

  assign ofn[0] = digital_output_a_function;
  assign ofn[1] = fast_output_a_function;
  assign ofn[2] = relay_output_a_function;
  assign ofn[3] = relay_output_b_function;

  for (gi = 0; gi < 4; gi++) begin : g_out
    assign ofn_sel_set[gi] = (ofn[gi] == `PEC_OUT_SET_REACHED);
    assign ofn_sel_des[gi] = (ofn[gi] == `PEC_OUT_DESIG_REACHED);
    assign next_out[gi] = (ofn_sel_set[gi] && (next_count == set_count_value)) ||
                          (ofn_sel_des[gi] && (next_count == desig_eff));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      accumulated_count  <= `PEC_COUNT_RESET_VAL;
      set_reached        <= 1'b0;
      designated_reached <= 1'b0;
      digital_output_a   <= 1'b0;
      fast_output_a      <= 1'b0;
      relay_output_a     <= 1'b0;
      relay_output_b     <= 1'b0;
    end else begin
      accumulated_count  <= next_count;
      set_reached        <= (next_count == set_count_value);
      designated_reached <= (next_count == desig_eff);
      digital_output_a   <= next_out[0];
      fast_output_a      <= next_out[1];
      relay_output_a     <= next_out[2];
      relay_output_b     <= next_out[3];
    end
  end

  property p_count_inc;
    @(posedge clk) disable iff (reset)
    (any_trig && !any_clr && !hit_set) |=> (accumulated_count == $past(accumulated_count) + 16'h1);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not increment");

  property p_count_clear;
    @(posedge clk) disable iff (reset)
    any_clr |=> (accumulated_count == 16'h0000);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared");

  property p_restart;
    @(posedge clk) disable iff (reset)
    (any_trig && hit_set) |=> (accumulated_count == 16'h0000);
  endproperty
  a_restart: assert property (p_restart) else $error("count did not restart");

  property p_set_out;
    @(posedge clk) disable iff (reset)
    (ofn_sel_set[0] && $stable(set_count_value) && $stable(digital_output_a_function))
      |-> (digital_output_a == (accumulated_count == set_count_value));
  endproperty
  a_set_out: assert property (p_set_out) else $error("set reached output wrong");

  property p_desig_out;
    @(posedge clk) disable iff (reset)
    (ofn_sel_des[1] && $stable(desig_eff) && $stable(fast_output_a_function))
      |-> (fast_output_a == hit_desig);
  endproperty
  a_desig_out: assert property (p_desig_out) else $error("designated output wrong");

  property p_type_gate;
    @(posedge clk) disable iff (reset)
    (tdig[0] != `PEC_TYPE_DIGITAL && tdig[1] != `PEC_TYPE_DIGITAL)
      |=> $stable(accumulated_count);
  endproperty
  a_type_gate: assert property (p_type_gate) else $error("non digital input changed count");

  property p_no_wrap;
    @(posedge clk) disable iff (reset)
    (accumulated_count == 16'hFFFF) |=> (accumulated_count != 16'h0000) || $past(any_clr)
      || $past(hit_set);
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("count wrapped");

  property p_one_per_edge;
    @(posedge clk) disable iff (reset)
    (!any_trig && !any_clr) |=> $stable(accumulated_count);
  endproperty
  a_one_per_edge: assert property (p_one_per_edge) else $error("count moved without edge");

  // the first edge after release still shows reset values, so it is skipped
  property p_relay_set;
    @(posedge clk) disable iff (reset)
    (!$past(reset) && ofn_sel_set[2] && $stable(set_count_value)
      && $stable(relay_output_a_function)) |-> (relay_output_a == hit_set);
  endproperty
  a_relay_set: assert property (p_relay_set) else $error("relay a set output wrong");

  property p_relay_des;
    @(posedge clk) disable iff (reset)
    (!$past(reset) && ofn_sel_des[3] && $stable(desig_eff)
      && $stable(relay_output_b_function)) |-> (relay_output_b == hit_desig);
  endproperty
  a_relay_des: assert property (p_relay_des) else $error("relay b desig output wrong");

  property p_flag_set;
    @(posedge clk) disable iff (reset)
    (!$past(reset) && $stable(set_count_value)) |-> (set_reached == hit_set);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("set reached flag wrong");

  property p_flag_desig;
    @(posedge clk) disable iff (reset)
    (!$past(reset) && $stable(desig_eff)) |-> (designated_reached == hit_desig);
  endproperty
  a_flag_desig: assert property (p_flag_desig) else $error("desig reached flag wrong");
endmodule

// ---- verif/pec_pulse_src.sv ----
`timescale 1ns/1ns
module pec_pulse_src (
  // clock
  input  wire logic       clk,
  // terminal pins, [0] input a, [1] input b
  output logic      [1:0] pins
);
  initial begin
    pins = 2'b00;
  end
  // high and low phases are held long enough to clear the synchroniser
  task automatic pulse(input int sel, input int hold);
    @(negedge clk);
    pins[sel] = 1'b1;
    repeat (hold) @(negedge clk);
    pins[sel] = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ---- verif/pulse_event_counter_bench.sv ----
`timescale 1ns/1ns
module pulse_event_counter_bench;
  logic                clk;
  logic                reset;
  logic [1:0]          pins;
  logic [7:0]          type_sel;
  logic [6:0]          fn_one;
  logic [6:0]          fn_two;
  logic [15:0]         set_val;
  logic [15:0]         desig_val;
  pec_pkg::pec_count_t count;
  logic [1:0]          a_type;
  logic [1:0]          b_type;
  logic                set_hit;
  logic                desig_hit;
  logic                do_a;
  logic                fo_a;
  logic                ro_a;
  logic                ro_b;
  int                  n_fail;
  int                  tests_run;

  pec_counter uut (.clk(clk), .reset(reset), .fast_input_a(pins[0]), .fast_input_b(pins[1]),
    .hs_input_type_select(type_sel), .hs_input_one_function(fn_one),
    .hs_input_two_function(fn_two), .set_count_value(set_val),
    .designated_count_value(desig_val), .digital_output_a_function(6'h12),
    .fast_output_a_function(6'h13), .relay_output_a_function(6'h12),
    .relay_output_b_function(6'h13), .accumulated_count(count), .input_a_type(a_type),
    .input_b_type(b_type), .set_reached(set_hit), .designated_reached(desig_hit),
    .digital_output_a(do_a), .fast_output_a(fo_a), .relay_output_a(ro_a),
    .relay_output_b(ro_b));
  pec_pulse_src src (.clk(clk), .pins(pins));

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_outs(input logic s, input logic d);
    chk("set_reached", 16'(s), 16'(set_hit));
    chk("digital_output_a", 16'(s), 16'(do_a));
    chk("relay_output_a", 16'(s), 16'(ro_a));
    chk("designated_reached", 16'(d), 16'(desig_hit));
    chk("fast_output_a", 16'(d), 16'(fo_a));
    chk("relay_output_b", 16'(d), 16'(ro_b));
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // count up to the set value, then one more pulse restarts the count at zero
  task automatic t_count;
    chk("accumulated_count", 16'h0000, count);
    chk_outs(1'b0, 1'b0);
    for (int i = 1; i <= 6; i++) begin
      src.pulse(0, 3);
      chk("accumulated_count", (i == 6) ? 16'h0000 : 16'(i), count);
      chk_outs(i == 5, i == 3);
    end
    $display("test count done");
  endtask
  task automatic t_clear;
    src.pulse(0, 3);
    src.pulse(0, 3);
    chk("accumulated_count", 16'h0002, count);
    src.pulse(1, 3);
    chk("accumulated_count", 16'h0000, count);
    $display("test clear done");
  endtask
  // pulse and speed types must neither count nor clear
  task automatic t_type;
    type_sel = 8'h21;
    @(negedge clk);
    chk("input_a_type", 16'h0001, 16'(a_type));
    chk("input_b_type", 16'h0002, 16'(b_type));
    src.pulse(0, 3);
    chk("accumulated_count", 16'h0001, count);
    for (int k = 0; k < 2; k++) begin
      type_sel = k ? 8'h02 : 8'h20;
      @(negedge clk);
      chk("input_a_type", k ? 16'h0002 : 16'h0000, 16'(a_type));
      chk("input_b_type", k ? 16'h0000 : 16'h0002, 16'(b_type));
      src.pulse(0, 3);
      src.pulse(1, 3);
      chk("accumulated_count", 16'h0001, count);
    end
    $display("test type done");
  endtask
  // designated above set is clamped, so both reach flags rise together at set
  task automatic t_clamp;
    type_sel = 8'h11;
    desig_val = 16'h0009;
    for (int i = 0; i < 4; i++) begin
      src.pulse(0, 3);
    end
    chk("accumulated_count", 16'h0005, count);
    chk_outs(1'b1, 1'b1);
    src.pulse(1, 3);
    chk("accumulated_count", 16'h0000, count);
    chk_outs(1'b0, 1'b0);
    $display("test clamp done");
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    n_fail = 0;
    tests_run = 0;
    reset = 1'b1;
    type_sel = 8'h11;
    fn_one = 7'h1F;
    fn_two = 7'h1C;
    set_val = 16'h0005;
    desig_val = 16'h0003;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_count();
    t_clear();
    t_type();
    t_clamp();
    report_and_stop();
  end
endmodule
